// ---- rtl/i2t_pin_if.sv ----
// Interface carrying synchronised bus levels and detected bus events.
// Assumes both ends run on the link clock.
`timescale 1ns/10ps
`default_nettype none

interface i2t_pin_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport src (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
	modport eng (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface

`default_nettype wire

// ---- rtl/i2t_pin_sync.sv ----
// Pin synchroniser and edge, start and stop detector on the link clock.
// Assumes raw SCL and SDA levels arrive asynchronously from the pads.
`timescale 1ns/10ps
`default_nettype none

module i2t_pin_sync #(
	parameter int STAGES = 2
) (
	input  wire logic link_clk,
	input  wire logic link_nrst,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	i2t_pin_if.src    pins
);
	logic [STAGES-1:0] scl_sh;
	logic [STAGES-1:0] sda_sh;
	logic              scl_q;
	logic              sda_q;

	if (STAGES < 2)
	begin : g_chk
		$error("i2t_pin_sync needs at least two synchroniser stages.");
	end

	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
		begin
			scl_sh <= '1;
			sda_sh <= '1;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end
		else
		begin
			scl_sh <= {scl_sh[STAGES-2:0], scl_pin}; // RQ26
			sda_sh <= {sda_sh[STAGES-2:0], sda_pin}; // RQ26
			scl_q  <= scl_sh[STAGES-1];
			sda_q  <= sda_sh[STAGES-1];
		end
	end

	assign pins.scl      = scl_sh[STAGES-1];
	assign pins.sda      = sda_sh[STAGES-1];
	assign pins.scl_rise = scl_sh[STAGES-1] & ~scl_q; // RQ26
	assign pins.scl_fall = ~scl_sh[STAGES-1] & scl_q; // RQ26
	assign pins.start    = scl_sh[STAGES-1] & scl_q & sda_q & ~sda_sh[STAGES-1]; // RQ26
	assign pins.stop     = scl_sh[STAGES-1] & scl_q & ~sda_q & sda_sh[STAGES-1]; // RQ26
endmodule

`default_nettype wire

// ---- rtl/i2t_pkg.sv ----
// Constants, event encoding and state type of the two-wire target port.
// Assumes one system clock domain for software bits and one link clock for the bus engine.
//
// What this block, its software and the bus master do
// RQ1: Matching read address sets direction, buffers, acknowledges.
// RQ2: After read acknowledge, hold SCL low.
// RQ3: Software loads byte, then releases the clock.
// RQ4: Shift eight bits, changing SDA while SCL low.
// RQ5: Sample master acknowledge on ninth rising edge.
// RQ6: Master not-acknowledge ends transfer, return idle.
// RQ7: Stretch after acknowledge; no stretch after not-acknowledge.
// RQ8: Software loads next byte after master acknowledge.
// RQ9: Interrupt flag set per byte, sticky.
// RQ10: Collision while sending sets flag, goes idle.
// RQ11: Start sets start_seen; interrupt only if enabled.
// RQ12: Buffer read clears full; write sets it.
// RQ13: Address hold: stretch and interrupt before acknowledge.
// RQ14: Software inspects status bits on address hold.
// RQ15: Software picks acknowledge value, device drives it.
// RQ16: Software loads data only after address acknowledge.
// RQ17: Master not-acknowledges last byte of a read.
// RQ18: Ten-bit high byte sets update flag, holds SCL.
// RQ19: Address writes only after acknowledge sequence ends.
// RQ20: Low byte mismatch still flags, no buffer fill.
// RQ21: Software restores high address after low byte.
// RQ22: Stretch after received data when stretch enabled.
// RQ23: Ten-bit hold points equal seven-bit ones.
// RQ24: First ten-bit byte compares against fixed pattern.
// RQ25: Hold SCL only once already low.
// RQ26: Synchronise pins, detect edges, start and stop.

package i2t_pkg;

	localparam int         BYTE_W     = 8;
	localparam logic [3:0] BIT_LAST   = 4'h8;
	localparam logic [4:0] TENBIT_TAG = 5'h1E;
	localparam logic [7:0] BYTE_RST   = 8'h00;

	localparam int EV_W     = 10;
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_ADDR  = 2;
	localparam int EV_DATA  = 3;
	localparam int EV_HOLD  = 4;
	localparam int EV_IRQ   = 5;
	localparam int EV_ACKT  = 6;
	localparam int EV_ACKS  = 7;
	localparam int EV_UA    = 8;
	localparam int EV_BCL   = 9;

	localparam int CFG_W    = 6;
	localparam int CFG_TEN  = 5;
	localparam int CFG_AH   = 4;
	localparam int CFG_DH   = 3;
	localparam int CFG_SEN  = 2;
	localparam int CFG_BCL  = 1;
	localparam int CFG_ACKV = 0;

	typedef enum logic [2:0]
	{
		I2T_IDLE,
		I2T_ADDR,
		I2T_ADDR_LO,
		I2T_ACK_ADDR,
		I2T_RX,
		I2T_ACK_RX,
		I2T_TX,
		I2T_ACK_TX
	} i2t_state_t;

endpackage

// ---- rtl/i2t_target.sv ----
// Two-wire bus target: software status and control bits on the system clock,
// the bus bit engine on the link clock.
// Assumes software pulses are one system clock wide and pins are open drain.
`timescale 1ns/10ps
`default_nettype none

module i2t_target (
	input  wire logic                    clock,
	input  wire logic                    nrst,
	input  wire logic                    link_clk,
	input  wire logic                    scl_in,
	output logic                         scl_out,
	output logic                         scl_oe,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe,
	input  wire logic                    ten_bit_mode,
	input  wire logic                    address_hold_en,
	input  wire logic                    data_hold_en,
	input  wire logic                    stretch_enable,
	input  wire logic                    slave_collision_detect_en,
	input  wire logic                    start_irq_en,
	input  wire logic                    ack_value,
	input  wire logic [i2t_pkg::BYTE_W-1:0] sw_wdata,
	input  wire logic                    sw_buf_write,
	input  wire logic                    sw_buf_read,
	input  wire logic                    sw_addr_write,
	input  wire logic                    sw_release_set,
	input  wire logic                    sw_irq_clear,
	input  wire logic                    sw_bcl_clear,
	output logic [i2t_pkg::BYTE_W-1:0]   shift_buffer,
	output logic [i2t_pkg::BYTE_W-1:0]   address_match_reg,
	output logic                         buffer_full,
	output logic                         clock_release,
	output logic                         ack_status,
	output logic                         ack_time,
	output logic                         serial_irq_flag,
	output logic                         bus_collision_flag,
	output logic                         read_write_flag,
	output logic                         data_address_flag,
	output logic                         start_seen,
	output logic                         stop_seen,
	output logic                         update_address
);
	import i2t_pkg::*;

	// ********************************************************************
	// Link reset and pin synchronisation.
	// ********************************************************************
	logic lrst_a;
	logic link_nrst;
	i2t_pin_if pins ();

	always_ff @(posedge link_clk)
	begin
		lrst_a    <= nrst;
		link_nrst <= lrst_a;
	end

	i2t_pin_sync #(.STAGES(2)) u_sync (
		.link_clk  (link_clk),
		.link_nrst (link_nrst),
		.scl_pin   (scl_in),
		.sda_pin   (sda_in),
		.pins      (pins)
	);

	// ********************************************************************
	// Crossings from the system clock into the link domain.
	// ********************************************************************
	logic             rel_tog;
	logic             load_tog;
	logic             addr_tog;
	logic [2:0]       tog_a;
	logic [2:0]       tog_b;
	logic [2:0]       tog_c;
	logic [CFG_W-1:0] cfg_a;
	logic [CFG_W-1:0] cfg;
	wire              rel_hit  = tog_b[0] ^ tog_c[0];
	wire              load_hit = tog_b[1] ^ tog_c[1];
	wire              addr_hit = tog_b[2] ^ tog_c[2];

	always_ff @(posedge link_clk)
	begin
		tog_a <= {addr_tog, load_tog, rel_tog};
		tog_b <= tog_a;
		tog_c <= tog_b;
		cfg_a <= {ten_bit_mode, address_hold_en, data_hold_en, stretch_enable,
			slave_collision_detect_en, ack_value};
		cfg   <= cfg_a;
	end

	// ********************************************************************
	// Bus bit engine on the link clock.
	// ********************************************************************
	i2t_state_t        state;
	i2t_state_t        next_state;
	logic [3:0]        cnt;
	logic [3:0]        next_cnt;
	logic [BYTE_W-1:0] shreg;
	logic [BYTE_W-1:0] next_shreg;
	logic              sda_drv;
	logic              next_sda_drv;
	logic              hold;
	logic              next_hold;
	logic              ua_hold;
	logic              next_ua_hold;
	logic              rw;
	logic              next_rw;
	logic              lo_phase;
	logic              next_lo_phase;
	logic              ten_ok;
	logic              next_ten_ok;
	logic              sw_ack;
	logic              next_sw_ack;
	logic              ack_bit;
	logic              next_ack_bit;
	logic [EV_W-1:0]   next_ev;
	logic [EV_W-1:0]   ev_vec;
	logic [BYTE_W-1:0] ev_byte;
	logic              ev_rw;
	logic              ev_ack;
	logic              ev_tog;

	function automatic logic addr_hit_fn(input logic [BYTE_W-1:0] rx, input logic [BYTE_W-1:0] am,
		input logic ten);
		addr_hit_fn = ten ? (rx[7:3] == TENBIT_TAG && rx[2:1] == am[2:1]) // RQ24
			: (rx[7:1] == am[7:1]);
	endfunction

	wire byte_end  = pins.scl_fall && cnt == BIT_LAST;
	wire hi_ok     = addr_hit_fn(shreg, address_match_reg, cfg[CFG_TEN]);
	wire read_ok   = !(cfg[CFG_TEN] && shreg[0] && !ten_ok);
	wire nack_sel  = sw_ack && cfg[CFG_ACKV];
	wire ack_drive = !nack_sel;

	always_comb
	begin
		next_state    = state;
		next_cnt      = cnt;
		next_shreg    = load_hit ? shift_buffer : shreg; // RQ3
		next_sda_drv  = sda_drv;
		next_hold     = rel_hit ? 1'b0 : hold;
		next_ua_hold  = addr_hit ? 1'b0 : ua_hold; // RQ18
		next_rw       = rw;
		next_lo_phase = lo_phase;
		next_ten_ok   = ten_ok;
		next_sw_ack   = sw_ack;
		next_ack_bit  = ack_bit;
		next_ev       = '0;
		if (pins.stop)
		begin
			next_state     = I2T_IDLE;
			next_sda_drv   = 1'b0;
			next_ten_ok    = 1'b0;
			next_ev[EV_STOP] = 1'b1;
		end
		else if (pins.start)
		begin
			next_state      = I2T_ADDR;
			next_cnt        = 4'h0;
			next_sda_drv    = 1'b0;
			next_ev[EV_START] = 1'b1; // RQ11
		end
		else
		begin
			case (state)
				I2T_ADDR, I2T_ADDR_LO, I2T_RX:
				begin
					if (pins.scl_rise)
					begin
						next_shreg = {shreg[BYTE_W-2:0], pins.sda};
						next_cnt   = cnt + 4'h1;
					end
					if (byte_end)
					begin
						next_cnt = 4'h0;
						if (state == I2T_RX)
						begin
							next_ev[EV_DATA] = 1'b1;
							next_state       = I2T_ACK_RX;
							next_sw_ack      = cfg[CFG_DH]; // RQ23
						end
						else if ((state == I2T_ADDR && hi_ok && read_ok)
							|| (state == I2T_ADDR_LO && shreg == address_match_reg))
						begin
							next_ev[EV_ADDR] = 1'b1; // RQ1
							next_rw       = (state == I2T_ADDR) && shreg[0]; // RQ1
							next_lo_phase = (state == I2T_ADDR_LO);
							next_state    = I2T_ACK_ADDR;
							next_sw_ack   = cfg[CFG_AH]; // RQ23
						end
						else if (state == I2T_ADDR_LO)
						begin
							next_ev[EV_UA]  = 1'b1; // RQ20
							next_ev[EV_IRQ] = 1'b1; // RQ20
							next_ua_hold    = 1'b1;
							next_state      = I2T_IDLE;
						end
						else
						begin
							next_state = I2T_IDLE;
						end
						if (next_sw_ack && next_state != I2T_IDLE)
						begin
							next_hold        = 1'b1; // RQ13
							next_ev[EV_HOLD] = 1'b1; // RQ13
							next_ev[EV_IRQ]  = 1'b1; // RQ13
							next_ev[EV_ACKT] = 1'b1;
						end
					end
				end
				I2T_ACK_ADDR, I2T_ACK_RX:
				begin
					if (!pins.scl && !pins.scl_fall)
					begin
						next_sda_drv = ack_drive; // RQ1 RQ15
					end
					if (pins.scl_fall)
					begin
						next_sda_drv = 1'b0;
						next_cnt     = 4'h0;
						next_state   = I2T_RX;
						if (nack_sel)
						begin
							next_state = I2T_IDLE;
						end
						else if (state == I2T_ACK_ADDR && rw)
						begin
							next_state       = I2T_TX;
							next_hold        = 1'b1; // RQ2
							next_ev[EV_HOLD] = 1'b1; // RQ2
							next_ev[EV_IRQ]  = 1'b1; // RQ9
						end
						else if (state == I2T_ACK_ADDR && cfg[CFG_TEN] && !ten_ok)
						begin
							next_state      = lo_phase ? I2T_RX : I2T_ADDR_LO;
							next_ten_ok     = lo_phase;
							next_ua_hold    = 1'b1; // RQ18
							next_ev[EV_UA]  = 1'b1; // RQ18
							next_ev[EV_IRQ] = 1'b1; // RQ9
						end
						else
						begin
							next_ev[EV_IRQ]  = 1'b1; // RQ9
							next_hold        = hold | cfg[CFG_SEN]; // RQ22
							next_ev[EV_HOLD] = cfg[CFG_SEN]; // RQ22
						end
					end
				end
				I2T_TX:
				begin
					if (!pins.scl && !pins.scl_fall)
					begin
						next_sda_drv = !shreg[BYTE_W-1]; // RQ4
					end
					if (pins.scl_rise && cfg[CFG_BCL] && !sda_drv && !pins.sda)
					begin
						next_ev[EV_BCL] = 1'b1; // RQ10
						next_state      = I2T_IDLE; // RQ10
						next_sda_drv    = 1'b0;
					end
					else if (pins.scl_fall)
					begin
						next_shreg = {shreg[BYTE_W-2:0], 1'b0}; // RQ4
						next_cnt   = cnt + 4'h1;
						if (cnt == BIT_LAST - 4'h1)
						begin
							next_state   = I2T_ACK_TX;
							next_sda_drv = 1'b0;
						end
					end
				end
				I2T_ACK_TX:
				begin
					if (pins.scl_rise)
					begin
						next_ack_bit     = pins.sda; // RQ5
						next_ev[EV_ACKS] = 1'b1; // RQ5
					end
					if (pins.scl_fall)
					begin
						next_cnt        = 4'h0;
						next_ev[EV_IRQ] = 1'b1; // RQ7 RQ9
						if (ack_bit)
						begin
							next_state = I2T_IDLE; // RQ6
						end
						else
						begin
							next_state       = I2T_TX;
							next_hold        = 1'b1; // RQ7
							next_ev[EV_HOLD] = 1'b1; // RQ7
						end
					end
				end
				default:
				begin
					next_state = I2T_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
		begin
			state    <= I2T_IDLE;
			cnt      <= 4'h0;
			shreg    <= BYTE_RST;
			sda_drv  <= 1'b0;
			hold     <= 1'b0;
			ua_hold  <= 1'b0;
			rw       <= 1'b0;
			lo_phase <= 1'b0;
			ten_ok   <= 1'b0;
			sw_ack   <= 1'b0;
			ack_bit  <= 1'b1;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			shreg    <= next_shreg;
			sda_drv  <= next_sda_drv;
			hold     <= next_hold;
			ua_hold  <= next_ua_hold;
			rw       <= next_rw;
			lo_phase <= next_lo_phase;
			ten_ok   <= next_ten_ok;
			sw_ack   <= next_sw_ack;
			ack_bit  <= next_ack_bit;
		end
	end

	// Events are published as a word with a toggle; the word stays until the next event.
	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
		begin
			ev_vec  <= '0;
			ev_byte <= BYTE_RST;
			ev_rw   <= 1'b0;
			ev_ack  <= 1'b1;
			ev_tog  <= 1'b0;
		end
		else if (|next_ev)
		begin
			ev_vec  <= next_ev;
			ev_byte <= shreg;
			ev_rw   <= next_rw;
			ev_ack  <= next_ack_bit;
			ev_tog  <= ~ev_tog;
		end
	end

	// The SCL pad is pulled low only after SCL is already low; the SDA pad follows sda_drv.
	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
		begin
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			scl_oe  <= (hold | ua_hold) & (scl_oe | ~pins.scl); // RQ25
			sda_oe  <= sda_drv;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// ********************************************************************
	// Software-facing bits on the system clock.
	// ********************************************************************
	logic      ev_a;
	logic      ev_b;
	logic      ev_c;
	wire       ev_hit  = ev_b ^ ev_c;
	wire       e_start = ev_hit & ev_vec[EV_START];
	wire       e_stop  = ev_hit & ev_vec[EV_STOP];
	wire       e_load  = ev_hit & (ev_vec[EV_ADDR] | ev_vec[EV_DATA]);
	wire       e_hold  = ev_hit & ev_vec[EV_HOLD];
	wire       e_irq   = ev_hit & (ev_vec[EV_IRQ] | (ev_vec[EV_START] & start_irq_en)); // RQ11
	wire       e_ua    = ev_hit & ev_vec[EV_UA];
	wire       e_bcl   = ev_hit & ev_vec[EV_BCL];

	always_ff @(posedge clock)
	begin
		ev_a <= ev_tog;
		ev_b <= ev_a;
		ev_c <= ev_b;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			shift_buffer      <= BYTE_RST;
			address_match_reg <= BYTE_RST;
			rel_tog           <= 1'b0;
			load_tog          <= 1'b0;
			addr_tog          <= 1'b0;
		end
		else
		begin
			shift_buffer      <= e_load ? ev_byte : (sw_buf_write ? sw_wdata : shift_buffer); // RQ1
			address_match_reg <= sw_addr_write ? sw_wdata : address_match_reg;
			rel_tog           <= rel_tog ^ sw_release_set; // RQ3
			load_tog          <= load_tog ^ sw_buf_write; // RQ3
			addr_tog          <= addr_tog ^ sw_addr_write; // RQ18
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			buffer_full        <= 1'b0;
			clock_release      <= 1'b1;
			serial_irq_flag    <= 1'b0;
			bus_collision_flag <= 1'b0;
			update_address     <= 1'b0;
		end
		else
		begin
			buffer_full        <= e_load | sw_buf_write | (buffer_full & ~sw_buf_read); // RQ12
			clock_release      <= sw_release_set | (clock_release & ~e_hold); // RQ2 RQ13
			serial_irq_flag    <= e_irq | (serial_irq_flag & ~sw_irq_clear); // RQ9
			bus_collision_flag <= e_bcl | (bus_collision_flag & ~sw_bcl_clear); // RQ10
			update_address     <= e_ua | (update_address & ~sw_addr_write); // RQ18
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ack_status        <= 1'b0;
			ack_time          <= 1'b0;
			read_write_flag   <= 1'b0;
			data_address_flag <= 1'b0;
			start_seen        <= 1'b0;
			stop_seen         <= 1'b0;
		end
		else if (ev_hit)
		begin
			ack_status        <= ev_vec[EV_ACKS] ? ev_ack : ack_status; // RQ5
			ack_time          <= ev_vec[EV_ACKT];
			read_write_flag   <= ev_vec[EV_ADDR] ? ev_rw : read_write_flag; // RQ1
			data_address_flag <= ev_vec[EV_DATA] | (data_address_flag & ~ev_vec[EV_ADDR]);
			start_seen        <= e_start | (start_seen & ~e_stop); // RQ11
			stop_seen         <= e_stop | (stop_seen & ~e_start);
		end
	end
endmodule

`default_nettype wire

// ---- verif/i2t_master_model.sv ----
// Behavioural bus master that clocks bytes in and out of the target.
// Assumes open drain lines with pull-ups resolved by the bench.
`timescale 1ns/10ps
`default_nettype none

module i2t_master_model #(
	parameter time T = 1600ns
) (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_low,
	output var  logic sda_low
);
	//****************************************
	// Bit and byte tasks
	//****************************************
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Releases SCL and waits while the target stretches it.
	task automatic hi();
		int n;
		scl_low = 1'b0;
		n = 0;
		while (scl !== 1'b1 && n < 4000)
			#10 n++;
		#T;
	endtask

	task automatic clk(input logic bv, output logic rv);
		sda_low = !bv;
		#T;
		hi();
		rv = sda;
		scl_low = 1'b1;
		#T;
	endtask

	task automatic start();
		sda_low = 1'b0;
		hi();
		sda_low = 1'b1;
		#T;
		scl_low = 1'b1;
		#T;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		#T;
		hi();
		sda_low = 1'b0;
		#T;
	endtask

	task automatic wr8(input logic [7:0] d);
		logic rv;
		for (int i = 7; i >= 0; i--)
			clk(d[i], rv);
	endtask

	task automatic rd8(input logic jam, output logic [7:0] d);
		logic rv;
		for (int i = 7; i >= 0; i--)
		begin
			clk(!jam, rv);
			d[i] = rv;
		end
	endtask
endmodule

`default_nettype wire

// ---- verif/i2t_target_assertions.sv ----
// Concurrent checks on the ports of the two-wire target.
// Assumes it is bound into i2t_target and sees its ports by name.
`timescale 1ns/10ps
`default_nettype none

module i2t_target_assertions (
	input wire logic                        clock,
	input wire logic                        nrst,
	input wire logic                        link_clk,
	input wire logic                        scl_in,
	input wire logic                        scl_oe,
	input wire logic                        sda_oe,
	input wire logic                        start_irq_en,
	input wire logic                        slave_collision_detect_en,
	input wire logic [i2t_pkg::BYTE_W-1:0] sw_wdata,
	input wire logic                        sw_buf_write,
	input wire logic                        sw_buf_read,
	input wire logic                        sw_addr_write,
	input wire logic                        sw_release_set,
	input wire logic                        sw_irq_clear,
	input wire logic                        sw_bcl_clear,
	input wire logic [i2t_pkg::BYTE_W-1:0] shift_buffer,
	input wire logic [i2t_pkg::BYTE_W-1:0] address_match_reg,
	input wire logic                        buffer_full,
	input wire logic                        clock_release,
	input wire logic                        serial_irq_flag,
	input wire logic                        bus_collision_flag,
	input wire logic                        start_seen,
	input wire logic                        update_address
);
	//****************************************
	// Software side and bus side relations
	//****************************************
	buf_write_a: assert property (@(posedge clock) disable iff (!nrst)
		sw_buf_write |=> buffer_full && shift_buffer == $past(sw_wdata)) else $error("buffer write");
	buf_read_a: assert property (@(posedge clock) disable iff (!nrst)
		sw_buf_read |=> !buffer_full) else $error("buffer read");
	addr_write_a: assert property (@(posedge clock) disable iff (!nrst)
		sw_addr_write |=> address_match_reg == $past(sw_wdata) && !update_address)
		else $error("address write");
	release_set_a: assert property (@(posedge clock) disable iff (!nrst)
		sw_release_set |=> clock_release) else $error("clock release");
	irq_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
		serial_irq_flag && !sw_irq_clear |=> serial_irq_flag) else $error("irq lost");
	start_irq_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(start_seen) && !$past(serial_irq_flag) |-> ##[0:2] serial_irq_flag == start_irq_en)
		else $error("start irq");
	bcl_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
		bus_collision_flag && !sw_bcl_clear |=> bus_collision_flag) else $error("bcl lost");
	bcl_enable_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(bus_collision_flag) |-> slave_collision_detect_en) else $error("bcl enable");
	scl_grab_a: assert property (@(posedge link_clk) disable iff (!nrst)
		$past(nrst, 2) && $rose(scl_oe) |-> !scl_in && $past(scl_in) == 1'b0)
		else $error("scl grab");
	sda_change_a: assert property (@(posedge link_clk) disable iff (!nrst)
		$past(nrst, 2) && $changed(sda_oe) |-> !scl_in) else $error("sda change");
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the two-wire target driven by a behavioural master.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import i2t_pkg::*;
	localparam int P_WR = 0, P_RD = 1, P_ADDR = 2, P_REL = 3, P_IRQC = 4, P_BCLC = 5;
	localparam logic [7:0] Y = 8'h01, N = 8'h00;
	logic       clock, nrst, link_clk, sie, m_scl, m_sda, r, scl_out, scl_oe, sda_out, sda_oe;
	logic [5:0] cfg, swp;
	logic [7:0] wd, v, shift_buffer, address_match_reg;
	logic       buffer_full, clock_release, ack_status, ack_time, serial_irq_flag;
	logic       bus_collision_flag, read_write_flag, data_address_flag, start_seen;
	logic       stop_seen, update_address;
	int         error_cnt = 0, tests_run = 0, cyc = 0;
	wire        scl_w = !(m_scl || scl_oe);
	wire        sda_w = !(m_sda || sda_oe);

	//****************************************
	// Design, master and clocks
	//****************************************
	i2t_target u_i2t_target (.clock, .nrst, .link_clk, .scl_in(scl_w), .scl_out, .scl_oe,
		.sda_in(sda_w), .sda_out, .sda_oe, .ten_bit_mode(cfg[CFG_TEN]),
		.address_hold_en(cfg[CFG_AH]), .data_hold_en(cfg[CFG_DH]),
		.stretch_enable(cfg[CFG_SEN]), .slave_collision_detect_en(cfg[CFG_BCL]),
		.start_irq_en(sie), .ack_value(cfg[CFG_ACKV]), .sw_wdata(wd), .sw_buf_write(swp[P_WR]),
		.sw_buf_read(swp[P_RD]), .sw_addr_write(swp[P_ADDR]), .sw_release_set(swp[P_REL]),
		.sw_irq_clear(swp[P_IRQC]), .sw_bcl_clear(swp[P_BCLC]), .shift_buffer,
		.address_match_reg, .buffer_full, .clock_release, .ack_status, .ack_time,
		.serial_irq_flag, .bus_collision_flag, .read_write_flag, .data_address_flag,
		.start_seen, .stop_seen, .update_address);
	i2t_master_model u_i2t_master_model (.scl(scl_w), .sda(sda_w), .scl_low(m_scl),
		.sda_low(m_sda));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #80 link_clk = ~link_clk;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	//****************************************
	// Shared tasks
	//****************************************
	function automatic logic [7:0] b(input logic x);
		return {7'h00, x};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wt();
		repeat (10) @(posedge clock);
		#2;
	endtask
	// Software pulses are kept well apart so that each crosses to the link side.
	task automatic pulse(input int k);
		@(posedge clock);
		#2 swp[k] = 1'b1;
		@(posedge clock);
		#2 swp[k] = 1'b0;
		repeat (14) @(posedge clock);
		#2;
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic ak();
		u_i2t_master_model.clk(1'b1, r);
	endtask
	task automatic sw8(input logic [7:0] a);
		u_i2t_master_model.start();
		u_i2t_master_model.wr8(a);
	endtask
	task automatic addr_read();
		sw8(8'hA5);
		ak();
		wt();
		pulse(P_RD);
		pulse(P_IRQC);
	endtask
	task automatic xfer(input logic [7:0] d, input logic nk);
		wd = d;
		pulse(P_WR);
		chk(b(buffer_full), Y);
		pulse(P_REL);
		u_i2t_master_model.rd8(1'b0, v);
		chk(v, d);
		u_i2t_master_model.clk(nk, r);
		wt();
		chk(b(ack_status), b(nk));
		chk(b(serial_irq_flag), Y);
		chk(b(clock_release), b(nk));
		chk(b(scl_oe), b(!nk));
		pulse(P_IRQC);
	endtask

	//****************************************
	// Scenarios
	//****************************************
	task automatic t_read();
		sie = 1'b1;
		wd = 8'hA4;
		pulse(P_ADDR);
		u_i2t_master_model.start();
		wt();
		chk(b(start_seen), Y);
		chk(b(serial_irq_flag), Y);
		pulse(P_IRQC);
		u_i2t_master_model.wr8(8'hA5);
		ak();
		chk(b(r), N);
		wt();
		chk(b(read_write_flag), Y);
		chk(shift_buffer, 8'hA5);
		chk(b(clock_release), N);
		chk(b(scl_oe), Y);
		pulse(P_RD);
		chk(b(buffer_full), N);
		pulse(P_IRQC);
		xfer(8'h3C, 1'b0);
		xfer(8'hC3, 1'b1);
		u_i2t_master_model.stop();
		chk(b(stop_seen), Y);
	endtask
	task automatic t_hold();
		sie = 1'b0;
		cfg[CFG_AH] = 1'b1;
		cfg[CFG_ACKV] = 1'b1;
		u_i2t_master_model.start();
		wt();
		chk(b(serial_irq_flag), N);
		u_i2t_master_model.wr8(8'hA5);
		wt();
		chk(b(clock_release), N);
		chk(b(serial_irq_flag), Y);
		chk(b(ack_time), Y);
		chk(b(scl_oe), Y);
		pulse(P_RD);
		pulse(P_IRQC);
		pulse(P_REL);
		ak();
		chk(b(r), Y);
		u_i2t_master_model.stop();
		cfg = '0;
		cfg[CFG_SEN] = 1'b1;
		sw8(8'hA4);
		ak();
		pulse(P_REL);
		u_i2t_master_model.wr8(8'h69);
		ak();
		wt();
		chk(b(data_address_flag), Y);
		chk(b(clock_release), N);
		pulse(P_REL);
		u_i2t_master_model.stop();
	endtask
	task automatic t_coll();
		cfg[CFG_BCL] = 1'b1;
		addr_read();
		wd = 8'hFF;
		pulse(P_WR);
		pulse(P_REL);
		u_i2t_master_model.rd8(1'b1, v);
		wt();
		chk(b(bus_collision_flag), Y);
		chk(b(sda_oe), N);
		ak();
		u_i2t_master_model.stop();
		pulse(P_BCLC);
		pulse(P_IRQC);
		cfg = '0;
	endtask
	task automatic t_ten();
		cfg[CFG_TEN] = 1'b1;
		wd = 8'h06;
		pulse(P_ADDR);
		sw8(8'hF6);
		ak();
		chk(b(r), N);
		wt();
		chk(b(update_address), Y);
		chk(b(scl_oe), Y);
		pulse(P_RD);
		pulse(P_IRQC);
		wd = 8'h5A;
		pulse(P_ADDR);
		chk(b(update_address), N);
		u_i2t_master_model.wr8(8'h5B);
		ak();
		wt();
		chk(b(update_address), Y);
		chk(b(serial_irq_flag), Y);
		chk(b(buffer_full), N);
		chk(b(clock_release), Y);
		wd = 8'h06;
		pulse(P_ADDR);
		u_i2t_master_model.stop();
	endtask

	initial
	begin
		nrst = 1'b0;
		sie = 1'b0;
		cfg = '0;
		swp = '0;
		wd = 8'h00;
		repeat (20) @(posedge clock);
		#2 nrst = 1'b1;
		repeat (4) @(posedge clock);
		#2;
		t_read();
		t_hold();
		t_coll();
		t_ten();
		give_verdict();
	end
endmodule

bind i2t_target i2t_target_assertions u_i2t_target_assertions (.clock, .nrst, .link_clk,
	.scl_in, .scl_oe, .sda_oe, .start_irq_en, .slave_collision_detect_en, .sw_wdata,
	.sw_buf_write, .sw_buf_read, .sw_addr_write, .sw_release_set, .sw_irq_clear,
	.sw_bcl_clear, .shift_buffer, .address_match_reg, .buffer_full, .clock_release,
	.serial_irq_flag, .bus_collision_flag, .start_seen, .update_address);

`default_nettype wire
